// ### pmwc_ctrl.sv
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
// Power mode and wakeup controller top: registers, mode FSM, power outputs.
// Assumes a single-cycle strobe register port driven by the core on ref_clk.
module pmwc_ctrl
	import pmwc_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Oscillator status
	input  wire logic        fast_crystal_osc_running,
	// Wakeup sources
	input  wire logic        wake_pin,
	input  wire logic        wake_tick,
	input  wire logic        wake_cmp,
	input  wire logic        radio_irq,
	input  wire logic        misc_irq_a,
	// Power, clock, reset and interrupt outputs
	output pmwc_power_t      power_en,
	output logic             fast_xtal_prestart,
	output logic             sys_reset_req,
	output logic             irq
);
	pmwc_state_t state_r;
	pmwc_state_t state_nxt;
	logic [7:0]  clk_src_r;
	logic [2:0]  slow_src_r;
	logic [2:0]  prev_mode_r;
	logic [2:0]  wake_flags_r;
	logic [PMWC_NUM_EVT-1:0] irq_stat_r;
	logic [PMWC_NUM_EVT-1:0] irq_en_r;
	logic [PMWC_CNT_W-1:0]   cnt_r;
	logic        short_ok_r;
	logic        timers_on;
	logic        enter_rr;
	logic        enter_sb;
	logic        enter_other;
	logic        woke;
	logic        short_pre;
	pmwc_wake_t  src;
	pmwc_wake_t  hit;
	logic [PMWC_NUM_EVT-1:0] evt;
	logic [PMWC_NUM_EVT-1:0] clr;

	assign src = '{pin: wake_pin, tick: wake_tick, cmp: wake_cmp,
		radio: radio_irq, misc: misc_irq_a};

	pmwc_wake_sel u_wake_sel (
		.mode      (state_r),
		.timers_on (timers_on),
		.src       (src),
		.hit       (hit)
	);

	// RULE13 timers-on variant
	assign timers_on = (slow_src_r != PMWC_SLOW_NONE) && (slow_src_r < PMWC_SLOW_RSV_LO);

	// RULE12 code 100 entry
	assign enter_rr = reg_wr && (reg_addr == PMWC_PWR_DOWN_SEL_ADDR)
		&& (reg_wdata[2:0] == PMWC_PD_REG_RET) && (state_r == PMWC_ACTIVE);
	// RULE15 code 111 entry
	assign enter_sb = reg_wr && (reg_addr == PMWC_PWR_DOWN_SEL_ADDR)
		&& (reg_wdata[2:0] == PMWC_PD_STANDBY) && (state_r == PMWC_ACTIVE);
	// Codes of modes outside this block only record the previous mode and clear the wake flags
	assign enter_other = reg_wr && (reg_addr == PMWC_PWR_DOWN_SEL_ADDR)
		&& (reg_wdata[2:0] inside {PMWC_PD_DEEP, PMWC_PD_MEM_OFF, PMWC_PD_MEM_ON})
		&& (state_r == PMWC_ACTIVE);

	assign woke = |hit;

	// RULE2 short pre-start cases
	assign short_pre = ((clk_src_r[PMWC_START_HI:PMWC_START_LO] == PMWC_START_RC_ONLY)
		|| clk_src_r[PMWC_KEEP_XTAL_BIT]) && short_ok_r;

	// Clock source and slow clock control registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			clk_src_r  <= PMWC_CLK_SRC_CTRL_RST;
			slow_src_r <= PMWC_SLOW_SRC_RST;
		end else if (reg_wr) begin
			if (reg_addr == PMWC_CLK_SRC_CTRL_ADDR) begin
				clk_src_r <= reg_wdata;
			end
			if (reg_addr == PMWC_SLOW_CLK_CTRL_ADDR) begin
				slow_src_r <= reg_wdata[2:0];
			end
		end
	end

	// RULE3 crystal running at entry
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			short_ok_r <= 1'b0;
		end else if (enter_rr) begin
			short_ok_r <= fast_crystal_osc_running;
		end
	end

	// Previous mode and wakeup cause flags, cleared by read or entry
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prev_mode_r  <= PMWC_PD_NONE;
			wake_flags_r <= 3'h0;
		end else begin
			if (enter_rr || enter_sb || enter_other) begin
				prev_mode_r  <= reg_wdata[2:0];
				wake_flags_r <= 3'h0;
			end else if (state_r == PMWC_REG_RET && woke) begin
				wake_flags_r <= {hit.pin, hit.tick, hit.cmp};
			end else if (reg_rd && reg_addr == PMWC_PWR_DOWN_SEL_ADDR) begin
				wake_flags_r <= 3'h0;
			end
		end
	end

	// Mode state machine
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PMWC_ACTIVE: begin
				if (enter_rr) begin
					state_nxt = PMWC_REG_RET;
				end else if (enter_sb) begin
					state_nxt = PMWC_STANDBY;
				end
			end
			PMWC_REG_RET: begin
				if (woke) begin
					state_nxt = PMWC_PRESTART;
				end
			end
			PMWC_STANDBY: begin
				if (woke) begin
					state_nxt = PMWC_RESTART;
				end
			end
			PMWC_PRESTART: begin
				if (cnt_r == '0) begin
					state_nxt = PMWC_ACTIVE;
				end
			end
			PMWC_RESTART: begin
				if (cnt_r == '0) begin
					state_nxt = PMWC_ACTIVE;
				end
			end
			default: state_nxt = PMWC_ACTIVE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= PMWC_ACTIVE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Start-up delay counter
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
		end else if (state_r == PMWC_REG_RET && woke) begin
			if (hit.tick && short_pre) begin
				cnt_r <= PMWC_CNT_W'(SHORT_PRESTART_CYC - 1);
			end else begin
				cnt_r <= PMWC_CNT_W'(LONG_PRESTART_CYC - 1);
			end
		end else if (state_r == PMWC_STANDBY && woke) begin
			// RULE8 about 100 ns
			cnt_r <= PMWC_CNT_W'(STANDBY_RESTART_CYC - 1);
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	// RULE4 no reset on wakeup
	// RULE16 resume without reset
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sys_reset_req <= 1'b0;
		end else begin
			sys_reset_req <= 1'b0;
		end
	end

	// RULE2 crystal pre-start window
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fast_xtal_prestart <= 1'b0;
		end else begin
			fast_xtal_prestart <= (state_nxt == PMWC_PRESTART);
		end
	end

	// Power domain outputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			power_en <= '1;
		end else begin
			case (state_nxt)
				PMWC_REG_RET: begin
					power_en.cpu_clk_en <= 1'b0;
					power_en.prog_mem   <= 1'b0;
					power_en.data_mem   <= 1'b0;
					power_en.voltage_regulator       <= 1'b0;
					power_en.fast_xtal  <= clk_src_r[PMWC_KEEP_XTAL_BIT];
					power_en.slow_clk   <= timers_on;
				end
				PMWC_STANDBY, PMWC_RESTART: begin
					// RULE9 processor clock stopped
					power_en.cpu_clk_en <= 1'b0;
					// RULE5 standby keeps memories
					power_en.prog_mem   <= 1'b1;
					power_en.data_mem   <= 1'b1;
					power_en.voltage_regulator       <= 1'b1;
					power_en.fast_xtal  <= 1'b1;
					power_en.slow_clk   <= timers_on;
				end
				PMWC_PRESTART: begin
					power_en.cpu_clk_en <= 1'b0;
					power_en.prog_mem   <= 1'b1;
					power_en.data_mem   <= 1'b1;
					power_en.voltage_regulator       <= 1'b1;
					power_en.fast_xtal  <= 1'b1;
					power_en.slow_clk   <= timers_on;
				end
				default: begin
					// RULE10 everything powered
					power_en <= '1;
				end
			endcase
		end
	end

	// Interrupt status, clear and enable
	assign evt = {hit.misc, hit.radio, hit.cmp, hit.tick, hit.pin};
	assign clr = (reg_wr && reg_addr == PMWC_IRQ_CLEAR_ADDR) ?
		reg_wdata[PMWC_NUM_EVT-1:0] : '0;

	genvar g;
	generate
		for (g = 0; g < PMWC_NUM_EVT; g++) begin : g_stat
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					irq_stat_r[g] <= 1'b0;
				end else if (evt[g]) begin
					irq_stat_r[g] <= 1'b1;
				end else if (clr[g]) begin
					irq_stat_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_en_r <= '0;
			irq      <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == PMWC_IRQ_ENABLE_ADDR) begin
				irq_en_r <= reg_wdata[PMWC_NUM_EVT-1:0];
			end
			irq <= |(irq_stat_r & irq_en_r);
		end
	end

	// Read data, valid the cycle after the read strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				PMWC_CLK_SRC_CTRL_ADDR:  reg_rdata <= clk_src_r;
				PMWC_PWR_DOWN_SEL_ADDR:  reg_rdata <= {wake_flags_r, 2'h0, prev_mode_r};
				PMWC_SLOW_CLK_CTRL_ADDR: reg_rdata <= {4'h0, fast_crystal_osc_running,
					slow_src_r};
				PMWC_IRQ_STATUS_ADDR:    reg_rdata <= {3'h0, irq_stat_r};
				PMWC_IRQ_ENABLE_ADDR:    reg_rdata <= {3'h0, irq_en_r};
				default:                 reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule

// ### pmwc_pkg.sv
// Package for the power mode and wakeup controller: offsets, fields, codes, timing.
// Assumes a 100 MHz ref_clk and a simple strobe register port from the core.
// Functional notes
// RULE1 - Register retention timers-on takes the same wakeups as memory retention timers-on.
// RULE2 - Tick wakeup uses short pre-start if crystal not started or kept on.
// RULE3 - No short pre-start if power-down entered before crystal was running.
// RULE4 - Register retention wakeup resumes execution without system reset.
// RULE5 - Standby also powers program memory, data memory, regulator and crystal.
// RULE6 - Standby also wakes on radio interrupt and misc interrupt.
// RULE7 - Standby ignores analog comparator wakeup.
// RULE8 - Processor restarts about 100 ns after standby wakeup.
// RULE9 - Standby stops processor clock; peripherals may keep running.
// RULE10 - Active mode powers everything and runs the processor.
// RULE11 - Software turns on the RC oscillator before deep sleep.
// RULE12 - Code 100 enters register retention, both timer variants.
// RULE13 - Active slow-clock source selects timers-on variant, else timers-off.
// RULE14 - Timers-on wakeups are pin, timer tick and comparator level.
// RULE15 - Code 111 enters standby and stops the processor clock.
// RULE16 - Standby wakeup restarts processor clock without reset.
package pmwc_pkg;
	// Register offsets
	localparam logic [7:0] PMWC_CLK_SRC_CTRL_ADDR  = 8'ha3;
	localparam logic [7:0] PMWC_PWR_DOWN_SEL_ADDR  = 8'ha4;
	localparam logic [7:0] PMWC_SLOW_CLK_CTRL_ADDR = 8'had;
	localparam logic [7:0] PMWC_IRQ_STATUS_ADDR    = 8'hb0;
	localparam logic [7:0] PMWC_IRQ_CLEAR_ADDR     = 8'hb1;
	localparam logic [7:0] PMWC_IRQ_ENABLE_ADDR    = 8'hb2;
	// Reset values
	localparam logic [7:0] PMWC_CLK_SRC_CTRL_RST   = 8'h00;
	localparam logic [2:0] PMWC_SLOW_SRC_RST       = 3'h7;
	// Field positions
	localparam int PMWC_KEEP_XTAL_BIT = 7;
	localparam int PMWC_START_HI      = 5;
	localparam int PMWC_START_LO      = 4;
	localparam int PMWC_XTAL_RUN_BIT  = 3;
	localparam int PMWC_WAKE_PIN_BIT  = 7;
	localparam int PMWC_WAKE_TICK_BIT = 6;
	localparam int PMWC_WAKE_CMP_BIT  = 5;
	// Start field code, slow-clock none code and lowest reserved slow-clock code
	localparam logic [1:0] PMWC_START_RC_ONLY = 2'h1;
	localparam logic [2:0] PMWC_SLOW_NONE     = 3'h7;
	localparam logic [2:0] PMWC_SLOW_RSV_LO   = 3'h5;
	// Power-down codes
	localparam logic [2:0] PMWC_PD_NONE      = 3'h0;
	localparam logic [2:0] PMWC_PD_DEEP      = 3'h1;
	localparam logic [2:0] PMWC_PD_MEM_OFF   = 3'h2;
	localparam logic [2:0] PMWC_PD_MEM_ON    = 3'h3;
	localparam logic [2:0] PMWC_PD_REG_RET   = 3'h4;
	localparam logic [2:0] PMWC_PD_STANDBY   = 3'h7;
	// Interrupt status bits: 0 pin, 1 tick, 2 comparator, 3 radio, 4 misc
	localparam int PMWC_NUM_EVT = 5;
	// Timing
	localparam int CLK_PERIOD_NS     = 10;
	localparam int STANDBY_RESTART_NS = 100;
	localparam int STANDBY_RESTART_CYC = STANDBY_RESTART_NS / CLK_PERIOD_NS;
	localparam int SHORT_PRESTART_CYC  = 4;
	localparam int LONG_PRESTART_CYC   = 64;
	localparam int PMWC_CNT_W          = 8;

	typedef enum logic [2:0] {
		PMWC_ACTIVE, PMWC_REG_RET, PMWC_STANDBY, PMWC_PRESTART, PMWC_RESTART
	} pmwc_state_t;

	typedef struct packed {
		logic pin;
		logic tick;
		logic cmp;
		logic radio;
		logic misc;
	} pmwc_wake_t;

	typedef struct packed {
		logic cpu_clk_en;
		logic prog_mem;
		logic data_mem;
		logic voltage_regulator;
		logic fast_xtal;
		logic slow_clk;
	} pmwc_power_t;
endpackage

// ### pmwc_wake_sel.sv
`timescale 1ns/10ps
// Wakeup source qualifier per power-down mode.
// Assumes wakeup inputs are synchronous levels or pulses on ref_clk.
module pmwc_wake_sel
	import pmwc_pkg::*;
(
	// Mode
	input  wire pmwc_state_t mode,
	input  wire logic        timers_on,
	// Sources
	input  wire pmwc_wake_t  src,
	// Qualified
	output pmwc_wake_t       hit
);
	always_comb begin
		hit = '0;
		case (mode)
			PMWC_REG_RET: begin
				// RULE1 timers-on sources
				// RULE14 pin tick comparator
				hit.pin  = src.pin;
				hit.tick = src.tick & timers_on;
				hit.cmp  = src.cmp & timers_on;
			end
			PMWC_STANDBY: begin
				hit.pin   = src.pin;
				hit.tick  = src.tick & timers_on;
				// RULE7 comparator ignored
				hit.cmp   = 1'b0;
				// RULE6 radio and misc
				hit.radio = src.radio;
				hit.misc  = src.misc;
			end
			default: hit = '0;
		endcase
	end
endmodule

// ### pmwc_ctrl_chk_sva.sv
// Port assertions for the power mode controller.
// Assumes it is bound into pmwc_ctrl: one clock, reset async high.
`timescale 1ns/10ps
module pmwc_ctrl_chk
	import pmwc_pkg::*;
(
	// Clock, reset and bus
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	// Wakeups
	input wire logic        wake_pin,
	input wire logic        wake_tick,
	input wire logic        radio_irq,
	input wire logic        misc_irq_a,
	// Watched outputs
	input wire pmwc_power_t power_en,
	input wire logic        fast_xtal_prestart,
	input wire logic        sys_reset_req
);
	logic       sb_r;
	logic       rr_r;
	logic       woke_r;
	logic [7:0] pre_cnt_r;
	logic       run;
	logic       pd_wr;
	logic       any_wk;
	assign run = power_en.cpu_clk_en;
	assign pd_wr = run && reg_wr && reg_addr == PMWC_PWR_DOWN_SEL_ADDR;
	assign any_wk = wake_pin || wake_tick || radio_irq || misc_irq_a;
	// Remembers the commanded power-down mode until the core runs again
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sb_r <= 1'b0;
			rr_r <= 1'b0;
		end else if (pd_wr) begin
			sb_r <= reg_wdata[2:0] == PMWC_PD_STANDBY;
			rr_r <= reg_wdata[2:0] == PMWC_PD_REG_RET;
		end else if (run) begin
			sb_r <= 1'b0;
			rr_r <= 1'b0;
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			woke_r <= 1'b0;
		end else begin
			woke_r <= !run && (woke_r || ((sb_r || rr_r) && any_wk));
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pre_cnt_r <= 8'h00;
		end else begin
			pre_cnt_r <= fast_xtal_prestart ? pre_cnt_r + 8'h01 : 8'h00;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	no_sys_reset_a:
		assert property (!sys_reset_req) else $error("wakeup raised a system reset");
	active_full_a:
		assert property (run |-> power_en == 6'h3f) else $error("running without full power");
	standby_entry_a:
		assert property (pd_wr && reg_wdata[2:0] == PMWC_PD_STANDBY |=> !run && power_en.prog_mem
			&& power_en.data_mem && power_en.voltage_regulator && power_en.fast_xtal)
		else $error("standby power set wrong");
	retention_entry_a:
		assert property (pd_wr && reg_wdata[2:0] == PMWC_PD_REG_RET |=> !run)
		else $error("retention did not stop the core");
	standby_hold_a:
		assert property (sb_r && !woke_r && !any_wk |=> !run) else $error("standby left unasked");
	standby_restart_a:
		assert property (sb_r && !woke_r && (radio_irq || misc_irq_a) |=> !run [*8] ##[1:4] run)
		else $error("standby restart time wrong");
	pin_prestart_a:
		assert property (rr_r && !woke_r && wake_pin |-> ##[1:3] fast_xtal_prestart)
		else $error("pin wakeup not taken");
	prestart_len_a:
		assert property ($fell(fast_xtal_prestart) |-> pre_cnt_r == 8'h04 || pre_cnt_r == 8'h40)
		else $error("pre-start length wrong");
	resume_a:
		assert property ($fell(fast_xtal_prestart) |-> ##[0:2] run) else $error("no resume");
	cover property (sb_r && radio_irq);
	cover property ($fell(fast_xtal_prestart) && pre_cnt_r == 8'h04);
	cover property ($fell(fast_xtal_prestart) && pre_cnt_r == 8'h40);
endmodule
bind pmwc_ctrl pmwc_ctrl_chk u_chk (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .wake_pin,
	.wake_tick, .radio_irq, .misc_irq_a, .power_en, .fast_xtal_prestart, .sys_reset_req);

// ### pmwc_core_model.sv
// Core model: master of the controller's register port.
// Assumes ref_clk is shared with the controller.
`timescale 1ns/10ps
module pmwc_core_model
	import pmwc_pkg::*;
(
	// Clock
	input  wire logic       ref_clk,
	// Register port
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Idle bus shows inverted values so stale data cannot pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
	task automatic deep(input logic [7:0] ctl);
		wr(PMWC_CLK_SRC_CTRL_ADDR, {ctl[7:6], 2'h0, ctl[3:0]});
		wr(PMWC_PWR_DOWN_SEL_ADDR, {5'h00, PMWC_PD_DEEP});
	endtask
endmodule

// ### tb.sv
// Self-checking bench for the power mode controller.
// Assumes the package, controller, checker and core model are compiled first.
`timescale 1ns/10ps
module tb;
	import pmwc_pkg::*;
	logic        ref_clk, rst, fast_crystal_osc_running, irq;
	logic        wake_pin, wake_tick, wake_cmp, radio_irq, misc_irq_a;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
	logic        reg_wr, reg_rd, fast_xtal_prestart, sys_reset_req;
	pmwc_power_t power_en;
	int          error_cnt, checks_done;
	pmwc_core_model core (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	pmwc_ctrl uut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.fast_crystal_osc_running, .wake_pin, .wake_tick, .wake_cmp, .radio_irq, .misc_irq_a,
		.power_en, .fast_xtal_prestart, .sys_reset_req, .irq);
	always #5 ref_clk = ~ref_clk;
	task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic complete_run;
		if (error_cnt == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// One-cycle wake event, bit order as the status register
	task automatic pulse(input int s);
		@(posedge ref_clk);
		{misc_irq_a, radio_irq, wake_cmp, wake_tick, wake_pin} <= 5'h01 << s;
		@(posedge ref_clk);
		{misc_irq_a, radio_irq, wake_cmp, wake_tick, wake_pin} <= 5'h00;
	endtask
	task automatic wait_run(output int n, output int p);
		n = 0;
		p = 0;
		#1;
		while (power_en.cpu_clk_en !== 1'b1 && n < 100) begin
			if (fast_xtal_prestart === 1'b1) p++;
			@(posedge ref_clk);
			#1;
			n++;
		end
	endtask
	task automatic t_regs;
		core.rd(PMWC_CLK_SRC_CTRL_ADDR, v);
		chk("clk_src_rst", v, PMWC_CLK_SRC_CTRL_RST);
		core.rd(PMWC_SLOW_CLK_CTRL_ADDR, v);
		chk("slow_ctrl_rst", v & 8'h0f, {4'h1, PMWC_SLOW_SRC_RST});
		core.wr(PMWC_CLK_SRC_CTRL_ADDR, 8'h93);
		core.rd(PMWC_CLK_SRC_CTRL_ADDR, v);
		chk("clk_src_rw", v, 8'h93);
		core.rd(8'h00, v);
		chk("unmapped", v, 8'h00);
		core.deep(8'h93);
		#1;
		chk("deep_not_modelled", power_en, 8'h3f);
		core.rd(PMWC_PWR_DOWN_SEL_ADDR, v);
		chk("deep_prev_mode", v, {5'h00, PMWC_PD_DEEP});
	endtask
	task automatic t_rr(input logic [2:0] slow, input logic [7:0] ctl, input logic xr,
		input int s, input int len);
		int n;
		int p;
		core.wr(PMWC_SLOW_CLK_CTRL_ADDR, {5'h00, slow});
		core.wr(PMWC_CLK_SRC_CTRL_ADDR, ctl);
		fast_crystal_osc_running <= xr;
		core.wr(PMWC_PWR_DOWN_SEL_ADDR, {5'h00, PMWC_PD_REG_RET});
		#1;
		chk("rr_entry", power_en.cpu_clk_en, 8'h00);
		pulse(s);
		if (len == 0) begin
			repeat (10) @(posedge ref_clk);
			#1;
			chk("rr_ignored", power_en.cpu_clk_en, 8'h00);
			s = 0;
			len = 64;
			pulse(s);
		end
		wait_run(n, p);
		chk("rr_prestart", p[7:0], len[7:0]);
		chk("rr_wake", power_en.cpu_clk_en, 8'h01);
		core.rd(PMWC_PWR_DOWN_SEL_ADDR, v);
		chk("rr_flags", v, (8'h80 >> s) | 8'h04);
		chk("rr_no_reset", sys_reset_req, 8'h00);
	endtask
	task automatic t_sb(input int s);
		int n;
		int p;
		core.wr(PMWC_PWR_DOWN_SEL_ADDR, {5'h00, PMWC_PD_STANDBY});
		#1;
		chk("sb_power", {3'h0, power_en[5:1]}, 8'h0f);
		pulse(2);
		repeat (15) @(posedge ref_clk);
		#1;
		chk("sb_cmp", power_en.cpu_clk_en, 8'h00);
		pulse(s);
		wait_run(n, p);
		chk("sb_restart", {7'h00, n >= 8 && n <= 12}, 8'h01);
		chk("sb_power_on", power_en, 8'h3f);
		chk("sb_no_reset", sys_reset_req, 8'h00);
	endtask
	task automatic t_irq;
		int n;
		int p;
		core.wr(PMWC_IRQ_CLEAR_ADDR, 8'h1f);
		core.rd(PMWC_IRQ_STATUS_ADDR, v);
		chk("irq_cleared", v, 8'h00);
		// Status bits record wakeups, so the misc event comes in standby
		core.wr(PMWC_PWR_DOWN_SEL_ADDR, {5'h00, PMWC_PD_STANDBY});
		pulse(4);
		wait_run(n, p);
		core.rd(PMWC_IRQ_STATUS_ADDR, v);
		chk("irq_status", v, 8'h10);
		chk("irq_masked", irq, 8'h00);
		core.wr(PMWC_IRQ_ENABLE_ADDR, 8'h10);
		@(posedge ref_clk);
		#1;
		chk("irq_raised", irq, 8'h01);
		core.rd(PMWC_IRQ_ENABLE_ADDR, v);
		chk("irq_enable", v, 8'h10);
		core.wr(PMWC_IRQ_CLEAR_ADDR, 8'h10);
		@(posedge ref_clk);
		#1;
		chk("irq_clear", irq, 8'h00);
	endtask
	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		fast_crystal_osc_running = 1'b1;
		{misc_irq_a, radio_irq, wake_cmp, wake_tick, wake_pin} = 5'h00;
		error_cnt = 0;
		checks_done = 0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		t_regs;
		t_rr(3'h7, 8'h00, 1'b1, 1, 0);
		t_rr(3'h7, 8'h00, 1'b1, 2, 0);
		t_rr(3'h1, 8'h20, 1'b1, 1, 64);
		t_rr(3'h1, 8'h10, 1'b1, 1, 4);
		t_rr(3'h0, 8'h80, 1'b1, 1, 4);
		t_rr(3'h4, 8'h10, 1'b0, 1, 64);
		t_rr(3'h1, 8'h20, 1'b1, 2, 64);
		t_rr(3'h1, 8'h20, 1'b1, 0, 64);
		t_sb(3);
		t_sb(4);
		t_sb(0);
		t_irq;
		complete_run;
	end
	initial begin
		#100000;
		error_cnt++;
		complete_run;
	end
endmodule
